// ### synth_profile_register_map.sv
`timescale 1ns/1ps
`include "synth_regs_defs.svh"
module synth_profile_register_map
   import synth_regs_pkg::*;
(
   input  wire logic         CORE_CLK_IN,
   input  wire logic         ARST_N_IN,
   input  wire logic [6:0]   S_AXI_AWADDR_IN,
   input  wire logic         S_AXI_AWVALID_IN,
   output logic              S_AXI_AWREADY_OUT,
   input  wire logic [31:0]  S_AXI_WDATA_IN,
   input  wire logic [3:0]   S_AXI_WSTRB_IN,
   input  wire logic         S_AXI_WVALID_IN,
   output logic              S_AXI_WREADY_OUT,
   output logic [1:0]        S_AXI_BRESP_OUT,
   output logic              S_AXI_BVALID_OUT,
   input  wire logic         S_AXI_BREADY_IN,
   input  wire logic [6:0]   S_AXI_ARADDR_IN,
   input  wire logic         S_AXI_ARVALID_IN,
   output logic              S_AXI_ARREADY_OUT,
   output logic [31:0]       S_AXI_RDATA_OUT,
   output logic [1:0]        S_AXI_RRESP_OUT,
   output logic              S_AXI_RVALID_OUT,
   input  wire logic         S_AXI_RREADY_IN,
   output profile_cfg_s      ACTIVE_CFG_OUT,
   output frac_pair_s        ACTIVE_FRAC_OUT,
   output logic [15:0]       DEVIATION_OUT [`NUM_DEV],
   output logic              FOURTH_ORDER_OUT,
   output logic              INTEGER_MODE_OUT
);
   // register index space: 0x00..0x16, unused entries unmapped
   localparam int NREG = 23;
   logic [15:0] regs [NREG];
   logic [15:0] p2_cfg [3:8];

   logic [4:0]  aw_idx;
   logic [4:0]  ar_idx;
   logic        aw_held;
   logic        w_held;
   logic [4:0]  aw_q;
   logic [31:0] w_q;
   logic [3:0]  s_q;

   function automatic logic mapped(input logic [4:0] idx);
      mapped = (idx >= `OFS_P1_DEN_LO) && (idx <= `OFS_P1_DEN_HI);
   endfunction : mapped

   function automatic logic [15:0] reset_val(input logic [4:0] idx);
      case (idx)
         `OFS_P1_NDIV:   reset_val = `RST_P1_NDIV;
         `OFS_P1_REFDIV: reset_val = `RST_P1_REFDIV;
         `OFS_P1_FILT:   reset_val = `RST_P1_FILT;
         `OFS_P1_OUTBUF: reset_val = `RST_P1_OUTBUF;
         `OFS_P1_FSK:    reset_val = `RST_P1_FSK;
         default:        reset_val = `RST_ZERO;
      endcase
   endfunction : reset_val

   assign aw_idx = S_AXI_AWADDR_IN[6:2];
   assign ar_idx = S_AXI_ARADDR_IN[6:2];

   // write channel: capture address and data in either order
   wire do_write = aw_held && w_held && !S_AXI_BVALID_OUT;
   assign S_AXI_AWREADY_OUT = !aw_held && !S_AXI_BVALID_OUT;
   assign S_AXI_WREADY_OUT  = !w_held && !S_AXI_BVALID_OUT;

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_q    <= 5'h00;
         w_q     <= 32'h0000_0000;
         s_q     <= 4'h0;
      end else begin
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_held <= 1'b1;
            aw_q    <= aw_idx;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_held <= 1'b1;
            w_q    <= S_AXI_WDATA_IN;
            s_q    <= S_AXI_WSTRB_IN;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT  <= `RESP_OKAY;
      end else if (do_write) begin
         S_AXI_BVALID_OUT <= 1'b1;
         S_AXI_BRESP_OUT  <= mapped(aw_q) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_BREADY_IN) begin
         S_AXI_BVALID_OUT <= 1'b0;
      end
   end

   // register storage, byte lanes 0 and 1 only; all bits kept as written
   generate
      for (genvar i = 0; i < NREG; i++) begin : g_reg
         wire hit = do_write && (aw_q == 5'(i)) && mapped(5'(i));
         always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
               regs[i] <= reset_val(5'(i));
            end else if (hit) begin
               if (s_q[0]) regs[i][`LO_BYTE] <= w_q[7:0];
               if (s_q[1]) regs[i][`HI_BYTE] <= w_q[15:8];
            end
         end
      end
   endgenerate

   // read channel
   wire rd_take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
   assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT  <= 32'h0000_0000;
         S_AXI_RRESP_OUT  <= `RESP_OKAY;
      end else if (rd_take) begin
         S_AXI_RVALID_OUT <= 1'b1;
         S_AXI_RDATA_OUT  <= mapped(ar_idx) ? {16'h0000, regs[ar_idx]}
                                            : 32'h0000_0000;
         S_AXI_RRESP_OUT  <= mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_RREADY_IN) begin
         S_AXI_RVALID_OUT <= 1'b0;
      end
   end

   // profile2 fields above 0x13 lie outside this map; inputs stay at reset
   always_comb begin
      for (int k = 3; k <= 8; k++) p2_cfg[k] = reset_val(5'(k + 16));
      p2_cfg[3] = `RST_ZERO;
      p2_cfg[4] = `RST_P1_NDIV;
      p2_cfg[5] = `RST_P1_REFDIV;
      p2_cfg[6] = `RST_P1_FILT;
      p2_cfg[7] = `RST_P1_OUTBUF;
      p2_cfg[8] = `RST_P1_FSK;
   end

   wire sel2 = regs[`OFS_CTRL][`BIT_PROF_SEL];
   wire [15:0] c4 = sel2 ? p2_cfg[4] : regs[`OFS_P1_NDIV];
   wire [15:0] c5 = sel2 ? p2_cfg[5] : regs[`OFS_P1_REFDIV];
   wire [15:0] c6 = sel2 ? p2_cfg[6] : regs[`OFS_P1_FILT];
   wire [15:0] c7 = sel2 ? p2_cfg[7] : regs[`OFS_P1_OUTBUF];
   wire [15:0] c8 = sel2 ? p2_cfg[8] : regs[`OFS_P1_FSK];

   // 24-bit fractions: upper byte above the 16-bit low word
   wire [23:0] p1_num = {regs[`OFS_P1_DEN_HI][`LO_BYTE],
                         regs[`OFS_P1_NUM]};
   wire [23:0] p1_den = {regs[`OFS_P1_DEN_HI][`HI_BYTE],
                         regs[`OFS_P1_DEN_LO]};
   wire [23:0] p2_num = {regs[`OFS_P2_FRAC_HI][`LO_BYTE],
                         regs[`OFS_P2_NUM_LO]};
   wire [23:0] p2_den = {regs[`OFS_P2_FRAC_HI][`HI_BYTE],
                         regs[`OFS_P2_DEN_LO]};

   profile_cfg_s next_cfg;
   always_comb begin
      next_cfg.prescaler_select       = c4[`BIT_PRESC];
      next_cfg.modulator_order        = c4[`FLD_ORDER];
      next_cfg.integer_divide         = c4[`FLD_NDIV];
      next_cfg.reference_postdivider  = c5[`HI_BYTE];
      next_cfg.reference_predivider   = c5[`LO_BYTE];
      next_cfg.third_pole_resistor    = c6[`FLD_R3];
      next_cfg.second_channel_divider = c6[`FLD_CHDIV2];
      next_cfg.first_channel_divider  = c6[`FLD_CHDIV1];
      next_cfg.detector_delay         = c6[`FLD_DELAY];
      next_cfg.reference_multiplier   = c6[`FLD_MULT];
      next_cfg.receive_power          = c7[`FLD_RX_PWR];
      next_cfg.transmit_output_enable = c7[`BIT_TX_EN];
      next_cfg.receive_output_enable  = c7[`BIT_RX_EN];
      next_cfg.fourth_pole_resistor   = c7[`FLD_R4];
      next_cfg.freq_shift_enable      = c8[`BIT_FSK_EN];
      next_cfg.extosc_channel_divider = c8[`FLD_EXT_DIV];
      next_cfg.extosc_select          = c8[`BIT_EXT_SEL];
      next_cfg.transmit_power         = c8[`FLD_TX_PWR];
   end

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         ACTIVE_CFG_OUT   <= '0;
         ACTIVE_FRAC_OUT  <= '0;
         FOURTH_ORDER_OUT <= 1'b0;
         INTEGER_MODE_OUT <= 1'b1;
      end else begin
         ACTIVE_CFG_OUT   <= next_cfg;
         ACTIVE_FRAC_OUT  <= sel2 ? {p2_num, p2_den} : {p1_num, p1_den};
         FOURTH_ORDER_OUT <= next_cfg.modulator_order >= `ORDER_MAX;
         INTEGER_MODE_OUT <= next_cfg.modulator_order == 3'h0;
      end
   end

   generate
      for (genvar d = 0; d < `NUM_DEV; d++) begin : g_dev
         always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
               DEVIATION_OUT[d] <= `RST_ZERO;
            end else begin
               DEVIATION_OUT[d] <= regs[`OFS_P1_DEV0 + d];
            end
         end
      end
   endgenerate
endmodule : synth_profile_register_map

// ### synth_regs_defs.svh
`ifndef SYNTH_REGS_DEFS_SVH
`define SYNTH_REGS_DEFS_SVH
`define OFS_P1_DEN_LO   5'h03
`define OFS_P1_NDIV     5'h04
`define OFS_P1_REFDIV   5'h05
`define OFS_P1_FILT     5'h06
`define OFS_P1_OUTBUF   5'h07
`define OFS_P1_FSK      5'h08
`define OFS_P1_DEV0     5'h09
`define OFS_P1_DEV7     5'h10
`define OFS_P2_FRAC_HI  5'h11
`define OFS_P2_NUM_LO   5'h12
`define OFS_P2_DEN_LO   5'h13
`define OFS_CTRL        5'h14
`define OFS_P1_NUM      5'h15
`define OFS_P1_DEN_HI   5'h16
`define RST_ZERO        16'h0000
`define RST_P1_NDIV     16'h0028
`define RST_P1_REFDIV   16'h0101
`define RST_P1_FILT     16'h8584
`define RST_P1_OUTBUF   16'h10A4
`define RST_P1_FSK      16'h0010
`define NUM_DEV         8
`define ORDER_MAX       3'h4
`define HI_BYTE         15:8
`define LO_BYTE         7:0
`define BIT_FSK_EN      10
`define FLD_EXT_DIV     9:6
`define BIT_EXT_SEL     5
`define FLD_TX_PWR      4:0
`define FLD_RX_PWR      12:8
`define BIT_TX_EN       7
`define BIT_RX_EN       6
`define FLD_R4          2:0
`define FLD_R3          15:13
`define FLD_CHDIV2      12:10
`define FLD_CHDIV1      9:8
`define FLD_DELAY       7:5
`define FLD_MULT        4:0
`define BIT_PRESC       15
`define FLD_ORDER       14:12
`define FLD_NDIV        11:0
`define BIT_PROF_SEL    0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ### synth_regs_pkg.sv
package synth_regs_pkg;
   typedef struct packed {
      logic        prescaler_select;
      logic [2:0]  modulator_order;
      logic [11:0] integer_divide;
      logic [7:0]  reference_postdivider;
      logic [7:0]  reference_predivider;
      logic [2:0]  third_pole_resistor;
      logic [2:0]  second_channel_divider;
      logic [1:0]  first_channel_divider;
      logic [2:0]  detector_delay;
      logic [4:0]  reference_multiplier;
      logic [4:0]  receive_power;
      logic        transmit_output_enable;
      logic        receive_output_enable;
      logic [2:0]  fourth_pole_resistor;
      logic        freq_shift_enable;
      logic [3:0]  extosc_channel_divider;
      logic        extosc_select;
      logic [4:0]  transmit_power;
   } profile_cfg_s;
   typedef struct packed {
      logic [23:0] frac_numerator;
      logic [23:0] frac_denominator;
   } frac_pair_s;
endpackage : synth_regs_pkg

// ### synth_map_monitor.sv
`timescale 1ns/1ps
module synth_map_monitor
   import synth_regs_pkg::*;
(
   input  wire logic          CORE_CLK_IN,
   input  wire logic          ARST_N_IN,
   input  wire logic          S_AXI_AWVALID_IN,
   input  wire logic          S_AXI_AWREADY_OUT,
   input  wire logic          S_AXI_WVALID_IN,
   input  wire logic          S_AXI_WREADY_OUT,
   input  wire logic          S_AXI_BVALID_OUT,
   input  wire logic [6:0]    S_AXI_ARADDR_IN,
   input  wire logic          S_AXI_ARVALID_IN,
   input  wire logic          S_AXI_ARREADY_OUT,
   input  wire logic [31:0]   S_AXI_RDATA_OUT,
   input  wire logic [1:0]    S_AXI_RRESP_OUT,
   input  wire logic          S_AXI_RVALID_OUT,
   input  wire profile_cfg_s  ACTIVE_CFG_OUT,
   input  wire logic          FOURTH_ORDER_OUT,
   input  wire logic          INTEGER_MODE_OUT
);
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   wire logic [4:0] ai = S_AXI_ARADDR_IN[6:2];
   wire logic       ar = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
   wire logic       bad = (ai < 5'h03) || (ai > 5'h16);
   a_read_answer: assert property (ar |=> S_AXI_RVALID_OUT)
      else $error("read not answered");
   a_read_unmapped: assert property (ar && bad |=>
      S_AXI_RRESP_OUT == 2'h2 && S_AXI_RDATA_OUT == 32'h0)
      else $error("unmapped read not refused");
   a_read_mapped: assert property (ar && !bad |=>
      S_AXI_RRESP_OUT == 2'h0) else $error("mapped read refused");
   a_upper_zero: assert property (S_AXI_RVALID_OUT |->
      S_AXI_RDATA_OUT[31:16] == 16'h0000) else $error("upper bits set");
   a_no_ar_busy: assert property (S_AXI_RVALID_OUT |->
      !S_AXI_ARREADY_OUT) else $error("read taken while busy");
   a_write_answer: assert property (S_AXI_AWVALID_IN &&
      S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT
      |-> ##[1:2] S_AXI_BVALID_OUT) else $error("write not answered");
   a_no_aw_busy: assert property (S_AXI_BVALID_OUT |->
      !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
      else $error("write taken while busy");
   a_integer_mode: assert property (INTEGER_MODE_OUT ==
      (ACTIVE_CFG_OUT.modulator_order == 3'h0))
      else $error("integer mode flag wrong");
   a_fourth_order: assert property (FOURTH_ORDER_OUT ==
      (ACTIVE_CFG_OUT.modulator_order >= 3'h4))
      else $error("fourth order flag wrong");
endmodule : synth_map_monitor
bind synth_profile_register_map synth_map_monitor mon (.*);

// ### host_model.sv
`timescale 1ns/1ps
module host_model (
   input  wire logic        clk_in,
   output logic [6:0]       awaddr_out,
   output logic             awvalid_out,
   input  wire logic        awready_in,
   output logic [31:0]      wdata_out,
   output logic [3:0]       wstrb_out,
   output logic             wvalid_out,
   input  wire logic        wready_in,
   input  wire logic [1:0]  bresp_in,
   input  wire logic        bvalid_in,
   output logic             bready_out,
   output logic [6:0]       araddr_out,
   output logic             arvalid_out,
   input  wire logic        arready_in,
   input  wire logic [31:0] rdata_in,
   input  wire logic [1:0]  rresp_in,
   input  wire logic        rvalid_in,
   output logic             rready_out
);
   initial begin
      {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out} = '0;
      {araddr_out, arvalid_out} = '0;
      {bready_out, rready_out} = 2'h3;
   end
   task automatic wr(input logic [4:0] i, input logic [15:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      awaddr_out  <= {i, 2'h0};
      wdata_out   <= {16'h0000, d};
      wstrb_out   <= s;
      awvalid_out <= 1'b1;
      wvalid_out  <= 1'b1;
      do begin
         @(posedge clk_in);
         if (awready_in) awvalid_out <= 1'b0;
         if (wready_in) wvalid_out <= 1'b0;
      end while (!bvalid_in);
      r = bresp_in;
   endtask : wr
   task automatic rd(input logic [4:0] i, output logic [31:0] d,
                     output logic [1:0] r);
      araddr_out  <= {i, 2'h0};
      arvalid_out <= 1'b1;
      do begin
         @(posedge clk_in);
         if (arready_in) arvalid_out <= 1'b0;
      end while (!rvalid_in);
      d = rdata_in;
      r = rresp_in;
   endtask : rd
endmodule : host_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
   import synth_regs_pkg::*;
   logic CORE_CLK_IN = 1'b0, ARST_N_IN = 1'b1;
   logic [6:0] S_AXI_AWADDR_IN, S_AXI_ARADDR_IN;
   logic [31:0] S_AXI_WDATA_IN, S_AXI_RDATA_OUT;
   logic [3:0] S_AXI_WSTRB_IN;
   logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
   logic S_AXI_AWVALID_IN, S_AXI_AWREADY_OUT, S_AXI_WVALID_IN;
   logic S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_BREADY_IN;
   logic S_AXI_ARVALID_IN, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT;
   logic S_AXI_RREADY_IN, FOURTH_ORDER_OUT, INTEGER_MODE_OUT;
   profile_cfg_s ACTIVE_CFG_OUT;
   frac_pair_s   ACTIVE_FRAC_OUT;
   logic [15:0]  DEVIATION_OUT [8];
   int miscompares = 0, samples_checked = 0;
   localparam logic [68:0] RST_CFG = {1'b0, 3'h0, 12'h028, 8'h01, 8'h01,
      3'h4, 3'h1, 2'h1, 3'h4, 5'h04, 5'h10, 2'h2, 3'h4, 6'h00, 5'h10};
   localparam logic [68:0] WR_CFG = {1'b0, 3'h4, 12'h3FF, 8'h03, 8'h02,
      3'h5, 3'h2, 2'h1, 3'h7, 5'h05, 5'h1F, 2'h3, 3'h7, 6'h3F, 5'h1F};
   logic [15:0] rst_v [3:19] = '{4: 16'h0028, 5: 16'h0101, 6: 16'h8584,
      7: 16'h10A4, 8: 16'h0010, default: 16'h0000};
   // reserved bits zero, divide below 1024, predivider below multiplier
   logic [15:0] wv [3:19] = '{16'h1234, 16'h43FF, 16'h0302,
      16'hA9E5,
      16'h1FC7, 16'h07FF, 16'hF009, 16'hF00A, 16'hF00B, 16'hF00C,
      16'hF00D, 16'hF00E, 16'hF00F, 16'hF010, 16'hABCD, 16'h5678, 16'h9ABC};
   always #5 CORE_CLK_IN = ~CORE_CLK_IN;
   synth_profile_register_map uut (.*);
   host_model host (.clk_in(CORE_CLK_IN), .awaddr_out(S_AXI_AWADDR_IN),
      .awvalid_out(S_AXI_AWVALID_IN), .awready_in(S_AXI_AWREADY_OUT),
      .wdata_out(S_AXI_WDATA_IN), .wstrb_out(S_AXI_WSTRB_IN),
      .wvalid_out(S_AXI_WVALID_IN), .wready_in(S_AXI_WREADY_OUT),
      .bresp_in(S_AXI_BRESP_OUT), .bvalid_in(S_AXI_BVALID_OUT),
      .bready_out(S_AXI_BREADY_IN), .araddr_out(S_AXI_ARADDR_IN),
      .arvalid_out(S_AXI_ARVALID_IN), .arready_in(S_AXI_ARREADY_OUT),
      .rdata_in(S_AXI_RDATA_OUT), .rresp_in(S_AXI_RRESP_OUT),
      .rvalid_in(S_AXI_RVALID_OUT), .rready_out(S_AXI_RREADY_IN));
   task automatic chk(input string n, input logic [68:0] e, s);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic w(input int i, input logic [15:0] d, input logic [3:0] s,
                    input logic [1:0] er);
      logic [1:0] r;
      host.wr(5'(i), d, s, r);
      chk("bresp", 69'(er), 69'(r));
   endtask : w
   task automatic rc(input int i, input logic [15:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      host.rd(5'(i), d, r);
      chk("rdata", 69'(e), 69'(d));
      chk("rresp", 69'(er), 69'(r));
   endtask : rc
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #100000;
      miscompares++;
      wrap_up();
   end
   initial begin
      // falling edge at time zero, in the NBA region after the initial 1, so the async reset really fires
      ARST_N_IN <= 1'b0;
      repeat (10) @(posedge CORE_CLK_IN);
      ARST_N_IN <= 1'b1;
      repeat (2) @(posedge CORE_CLK_IN);
      #1 chk("cfg", RST_CFG, ACTIVE_CFG_OUT);
      chk("intmode", 69'h1, 69'(INTEGER_MODE_OUT));
      @(posedge CORE_CLK_IN);
      for (int i = 3; i < 20; i++) rc(i, rst_v[i], 2'h0);
      $display("test reset values done");
      for (int i = 3; i < 20; i++) w(i, wv[i], 4'h3, 2'h0);
      for (int i = 3; i < 20; i++) rc(i, wv[i], 2'h0);
      #1 chk("cfg", WR_CFG, ACTIVE_CFG_OUT);
      chk("fourth", 69'h1, 69'(FOURTH_ORDER_OUT));
      for (int k = 0; k < 8; k++) begin
         chk("dev", 69'(16'hF009 + k), 69'(DEVIATION_OUT[k]));
      end
      $display("test write readback done");
      for (int p = 1; p >= 0; p--) begin
         @(posedge CORE_CLK_IN);
         w(5'h14, 16'(p), 4'h3, 2'h0);
         repeat (3) @(posedge CORE_CLK_IN);
         #1 chk("frac", p ? {24'hCD5678, 24'hAB9ABC} : 48'h001234,
                ACTIVE_FRAC_OUT);
      end
      $display("test profile select done");
      @(posedge CORE_CLK_IN);
      w(5'h12, 16'hFFFF, 4'h1, 2'h0);
      rc(5'h12, 16'h56FF, 2'h0);
      w(5'h13, 16'h0000, 4'h2, 2'h0);
      rc(5'h13, 16'h00BC, 2'h0);
      w(5'h17, 16'hFFFF, 4'h3, 2'h2);
      rc(5'h02, 16'h0000, 2'h2);
      rc(5'h17, 16'h0000, 2'h2);
      $display("test strobes and unmapped done");
      wrap_up();
   end
endmodule : testbench
